// *** verilog/ur_ctrl.sv ***
// Unit record controller core: status words, transfer pacing and busy timing.
// Assumes an APB master on pclk and a memory-transfer channel on the same clock.
// Operation
// - Status word loaded only on status request
// - Printer word: on-line bit 9, ready 10
// - Reader word: on-line, illegal code, overrun
// - Empty hopper sets bit 14, no transfer
// - Card not fed sets reader bit 15
// - Light or dark check failure: bit 16
// - Punch word: on-line 13, overrun 14
// - Punch attention bit 15, check bit 16
// - Printer requests at most one per 35 us
// - Reader column 2 ms, char mode half rate
// - After end-of-range finish card, store nothing
// - 8 ms stacking delays next read action
// - Punch column 6.25 ms, char mode 12.5
// - Punch ends busy on end-of-range
// - Eject 88 ms or 120 ms blocks punch
// - Non-peripheral commands busy for 7 us
// - Print busy only during line transfer
// - Read busy 190 ms, 198 with stacking
// - Punch busy 6.25 ms per column plus eject
// - One output command at a time
// - Busy from command receipt to completion
`timescale 1ns/1ns
module ur_ctrl #(
   parameter int unsigned RDR_COL_CYC = ur_pkg::RDR_COL_CYC,
   parameter int unsigned RDR_FEED_CYC = ur_pkg::RDR_FEED_CYC,
   parameter int unsigned STACK_CYC = ur_pkg::STACK_CYC,
   parameter int unsigned PCH_COL_CYC = ur_pkg::PCH_COL_CYC,
   parameter int unsigned EJECT_FAST_CYC = ur_pkg::EJECT_FAST_CYC,
   parameter int unsigned EJECT_SLOW_CYC = ur_pkg::EJECT_SLOW_CYC
)(
   input logic pclk,
   input logic presetn,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input ur_pkg::ur_pins_s pins,
   output logic mem_req,
   output logic mem_to_memory,
   input logic mem_ack,
   input logic mem_eor,
   output logic busy
);
   import ur_pkg::*;

   localparam int ASRT_SHORT = 701;

   logic [PIN_W-1:0] pins_v;
   logic [PIN_W-1:0] meta_q;
   logic [PIN_W-1:0] sync_q;
   ur_pins_s ps;
   ur_state_e state_q;
   ur_cnt_t pace_q;
   ur_cnt_t stack_q;
   ur_cnt_t eject_q;
   logic [6:0] col_q;
   logic [7:0] reqs_q;
   logic [15:0] cmd_q;
   logic [15:0] data_q;
   logic [15:0] cmd_w;
   logic [15:0] prn_word;
   logic [15:0] rdr_word;
   logic [15:0] pch_word;
   logic [4:0] rdr_flags_q;
   logic [4:0] rdr_set;
   logic [1:0] pch_flags_q;
   logic [1:0] pch_set;
   logic [1:0] dev_w;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [31:0] rd_d;
   logic err_d;
   logic ready_q;
   logic busy_q;
   logic mem_req_q;
   logic to_mem_q;
   logic binary_q;
   logic eor_seen_q;
   logic acc;
   logic xfer;
   logic start;
   logic tick;
   logic req_due;
   logic rdr_req_set;
   logic pch_req_set;
   logic prn_req_set;
   logic rdr_ovr_set;
   logic pch_ovr_set;
   logic stack_start;
   logic eject_start;
   logic rdr_go;

   assign pins_v = pins;

   // Pins from the peripherals are asynchronous, two flops before use
   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi++)
      begin : g_sync
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               meta_q[gi] <= 1'b0;
               sync_q[gi] <= 1'b0;
            end
            else
            begin
               meta_q[gi] <= pins_v[gi];
               sync_q[gi] <= meta_q[gi];
            end
         end
      end
   endgenerate
   assign ps = ur_pins_s'(sync_q);

   // APB: one wait state so that read data comes from a flop
   assign acc = psel & penable & ~pready_q;
   assign xfer = psel & penable & pready_q;
   assign cmd_w = pwdata[15:0];
   assign dev_w = cmd_w[CMD_DEV_LSB +: 2];
   assign start = xfer & pwrite & (paddr == REG_CMD) & ~pslverr_q;

   always_comb
   begin
      rd_d = 32'h0000_0000;
      err_d = 1'b0;
      if (paddr == REG_CMD)
      begin
         rd_d = {16'h0000, cmd_q};
         err_d = pwrite & (state_q != UR_IDLE);
      end
      else if (paddr == REG_DATA)
      begin
         rd_d = {16'h0000, data_q};
      end
      else if (paddr == REG_STAT)
      begin
         rd_d[STAT_BUSY] = busy_q;
         rd_d[STAT_READY] = ready_q;
         rd_d[STAT_STACKING] = (stack_q != '0);
         rd_d[STAT_EJECTING] = (eject_q != '0);
         rd_d[STAT_STATE_LSB +: 3] = state_q;
      end
      else if (paddr == REG_COLS)
      begin
         rd_d = {25'h0000000, col_q};
      end
      else
      begin
         err_d = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         pready_q <= acc;
         pslverr_q <= acc & err_d;
         prdata_q <= (acc & ~pwrite) ? rd_d : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cmd_q <= CMD_RESET;
      else if (start)
         cmd_q <= cmd_w;
   end

   always_comb
   begin
      prn_word = 16'h0000;
      rdr_word = 16'h0000;
      pch_word = 16'h0000;
      prn_word[ST_PRN_ONLINE] = ps.prn_online;
      prn_word[ST_PRN_READY] = ps.prn_ready;
      rdr_word[ST_RDR_ONLINE] = ps.rdr_online;
      rdr_word[ST_RDR_ILLEGAL] = rdr_flags_q[4];
      rdr_word[ST_RDR_OVERRUN] = rdr_flags_q[3];
      rdr_word[ST_RDR_HOPPER] = rdr_flags_q[2];
      rdr_word[ST_RDR_MOTION] = rdr_flags_q[1];
      rdr_word[ST_RDR_RDCHK] = rdr_flags_q[0];
      pch_word[ST_PCH_ONLINE] = ps.pch_online;
      pch_word[ST_PCH_OVERRUN] = pch_flags_q[1];
      // Attention is live, data check is sticky
      pch_word[ST_PCH_ATTN] = ps.pch_attn;
      pch_word[ST_PCH_CHECK] = pch_flags_q[0];
   end

   // Data register only changes on a status request
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         data_q <= 16'h0000;
         ready_q <= 1'b0;
      end
      else if (start & cmd_w[CMD_STATUS_BIT] & (dev_w != DEV_CTRL))
      begin
         data_q <= (dev_w == DEV_PRN) ? prn_word : (dev_w == DEV_RDR) ? rdr_word : pch_word;
         ready_q <= 1'b1;
      end
      else if (xfer & ~pwrite & (paddr == REG_DATA))
         ready_q <= 1'b0;
   end

   // Pacing and request decisions
   assign tick = (pace_q == '0);
   assign req_due = tick & (binary_q | col_q[0]);
   // Past end-of-range the card is read but not stored
   assign rdr_req_set = (state_q == UR_READ) & req_due & ~mem_req_q & ~eor_seen_q;
   assign pch_req_set = (state_q == UR_PUNCH) & req_due & ~mem_req_q & ~eor_seen_q;
   // One request per pacing interval, stalled while one is pending
   assign prn_req_set = (state_q == UR_PRINT) & tick & ~mem_req_q & ~eor_seen_q
      & (reqs_q != 8'(PRN_XFERS));
   assign rdr_ovr_set = (state_q == UR_READ) & req_due & mem_req_q & ~eor_seen_q;
   assign pch_ovr_set = (state_q == UR_PUNCH) & req_due & mem_req_q & ~eor_seen_q;
   assign stack_start = (state_q == UR_READ) & tick & (col_q == 7'(CARD_COLS - 1));
   assign eject_start = (state_q == UR_PUNCH) & (eor_seen_q | (col_q == 7'(CARD_COLS)));
   // Reader waits out the stacking interval
   assign rdr_go = (state_q == UR_RWAIT) & (stack_q == '0);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= UR_IDLE;
         busy_q <= 1'b0;
         pace_q <= '0;
         col_q <= 7'h00;
         reqs_q <= 8'h00;
         binary_q <= 1'b0;
         to_mem_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            UR_IDLE:
            begin
               if (start)
               begin
                  busy_q <= 1'b1;
                  col_q <= 7'h00;
                  reqs_q <= 8'h00;
                  binary_q <= cmd_w[CMD_BINARY_BIT];
                  to_mem_q <= (dev_w == DEV_RDR);
                  pace_q <= '0;
                  if (cmd_w[CMD_STATUS_BIT] | ~cmd_w[CMD_XFER_BIT] | (dev_w == DEV_CTRL))
                  begin
                     state_q <= UR_SHORT;
                     pace_q <= ur_cnt_t'(SHORT_CYC - 1);
                  end
                  else if (dev_w == DEV_PRN)
                     state_q <= UR_PRINT;
                  else if (dev_w == DEV_RDR)
                     state_q <= UR_RWAIT;
                  else
                     state_q <= UR_PWAIT;
               end
            end
            UR_SHORT:
            begin
               if (tick)
               begin
                  state_q <= UR_IDLE;
                  busy_q <= 1'b0;
               end
               else
                  pace_q <= pace_q - ur_cnt_t'(1);
            end
            UR_PRINT:
            begin
               // Free once the line is handed over
               if ((eor_seen_q | (reqs_q == 8'(PRN_XFERS))) & ~mem_req_q)
               begin
                  state_q <= UR_IDLE;
                  busy_q <= 1'b0;
               end
               else if (prn_req_set)
               begin
                  reqs_q <= reqs_q + 8'h01;
                  pace_q <= ur_cnt_t'(PRN_REQ_CYC - 1);
               end
               else if (!tick)
                  pace_q <= pace_q - ur_cnt_t'(1);
            end
            UR_RWAIT:
            begin
               if (rdr_go & ps.rdr_hopper_empty)
               begin
                  // Nothing to read, end as a short command
                  state_q <= UR_SHORT;
                  pace_q <= ur_cnt_t'(SHORT_CYC - 1);
               end
               else if (rdr_go)
               begin
                  // Card feed plus 80 columns gives the read busy time
                  state_q <= UR_READ;
                  pace_q <= ur_cnt_t'(RDR_FEED_CYC + RDR_COL_CYC - 1);
               end
            end
            UR_READ:
            begin
               if (tick)
               begin
                  col_q <= col_q + 7'h01;
                  pace_q <= ur_cnt_t'(RDR_COL_CYC - 1);
                  if (stack_start)
                  begin
                     state_q <= UR_IDLE;
                     busy_q <= 1'b0;
                  end
               end
               else
                  pace_q <= pace_q - ur_cnt_t'(1);
            end
            UR_PWAIT:
            begin
               if (eject_q == '0)
               begin
                  state_q <= UR_PUNCH;
                  pace_q <= '0;
               end
            end
            UR_PUNCH:
            begin
               // End-of-range ends the card whatever the count
               if (eject_start)
               begin
                  state_q <= UR_IDLE;
                  busy_q <= 1'b0;
               end
               else if (tick)
               begin
                  col_q <= col_q + 7'h01;
                  pace_q <= ur_cnt_t'(PCH_COL_CYC - 1);
               end
               else
                  pace_q <= pace_q - ur_cnt_t'(1);
            end
            default:
            begin
               state_q <= UR_IDLE;
               busy_q <= 1'b0;
            end
         endcase
      end
   end

   // Request stays up until the channel acknowledges it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mem_req_q <= 1'b0;
      else
         mem_req_q <= rdr_req_set | pch_req_set | prn_req_set | (mem_req_q & ~mem_ack);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         eor_seen_q <= 1'b0;
      else if (start)
         eor_seen_q <= 1'b0;
      else if (mem_ack & mem_req_q & mem_eor)
         eor_seen_q <= 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         stack_q <= '0;
      else if (stack_start)
         stack_q <= ur_cnt_t'(STACK_CYC);
      else if (stack_q != '0)
         stack_q <= stack_q - ur_cnt_t'(1);
   end

   // Eject time depends on columns punched
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         eject_q <= '0;
      else if (eject_start & (state_q == UR_PUNCH))
         eject_q <= (col_q > 7'(EJECT_FAST_COLS)) ? ur_cnt_t'(EJECT_FAST_CYC)
            : ur_cnt_t'(EJECT_SLOW_CYC);
      else if (eject_q != '0)
         eject_q <= eject_q - ur_cnt_t'(1);
   end

   // Sticky error flags; a new transfer order to the device clears them, a same-cycle event still sets
   always_comb
   begin
      // Illegal code only matters in character mode
      rdr_set[4] = (state_q == UR_READ) & ps.rdr_illegal & ~binary_q;
      rdr_set[3] = rdr_ovr_set;
      rdr_set[2] = rdr_go & ps.rdr_hopper_empty;
      rdr_set[1] = (state_q == UR_READ) & ps.rdr_motion_fail;
      rdr_set[0] = (state_q == UR_READ) & (ps.rdr_light_fail | ps.rdr_dark_fail);
      pch_set[1] = pch_ovr_set;
      // Card rejected on a check failure
      pch_set[0] = ps.pch_check_fail;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rdr_flags_q <= 5'h00;
         pch_flags_q <= 2'h0;
      end
      else
      begin
         rdr_flags_q <= (rdr_flags_q & ~{5{start & cmd_w[CMD_XFER_BIT] & (dev_w == DEV_RDR)}})
            | rdr_set;
         pch_flags_q <= (pch_flags_q & ~{2{start & cmd_w[CMD_XFER_BIT] & (dev_w == DEV_PCH)}})
            | pch_set;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign mem_req = mem_req_q;
   assign mem_to_memory = to_mem_q;
   assign busy = busy_q;

   // Cycles since the last printer request, for the pacing check
   logic [15:0] gap_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gap_q <= 16'hFFFF;
      else if (prn_req_set)
         gap_q <= 16'h0000;
      else if (gap_q != 16'hFFFF)
         gap_q <= gap_q + 16'h0001;
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   busy_on_cmd_a: assert property (start |=> busy_q)
      else $error("busy not raised on accepted command");
   one_cmd_a: assert property ((state_q != UR_IDLE) |-> !start)
      else $error("command accepted while another runs");
   short_time_a: assert property (
      ($past(state_q) == UR_IDLE && state_q == UR_SHORT) |-> busy_q [*8] ##[1:ASRT_SHORT]
      (state_q == UR_IDLE && !busy_q))
      else $error("short command busy time wrong");
   prn_pace_a: assert property ((prn_req_set && reqs_q != 8'h00)
      |-> gap_q >= 16'(PRN_REQ_CYC - 1))
      else $error("printer requests too close");
   status_load_a: assert property ($rose(ready_q) |-> $past(start)
      && $past(cmd_w[CMD_STATUS_BIT]))
      else $error("data register loaded without status request");
   unused_zero_a: assert property (data_q[15:8] == 8'h00)
      else $error("unused status bits not zero");
   eor_nostore_a: assert property ((eor_seen_q && state_q == UR_READ)
      |-> !rdr_req_set ##1 !$rose(mem_req_q))
      else $error("reader stored data past end of range");
   hopper_a: assert property ((rdr_go && ps.rdr_hopper_empty)
      |=> rdr_flags_q[2] && !mem_req_q [*3])
      else $error("empty hopper handled wrongly");
   stack_hold_a: assert property ((stack_q != '0) |-> state_q != UR_READ)
      else $error("read started during stacking");
   eject_hold_a: assert property ((eject_q != '0) |-> state_q != UR_PUNCH)
      else $error("punch started during ejection");
   punch_end_a: assert property ((state_q == UR_PUNCH && eor_seen_q)
      |=> !busy_q && eject_q != '0)
      else $error("punch did not end on end of range");

endmodule // ur_ctrl

// *** verilog/ur_pkg.sv ***
// Constants, types and register map of the unit record status and pacing block.
// Assumes a single 100 MHz APB clock and one paced memory-transfer channel.
package ur_pkg;

   // Clock and timing, times in their printed unit, cycles derived from them
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned T_SHORT_US = 7;
   localparam int unsigned T_PRN_REQ_US = 35;
   localparam int unsigned T_RDR_COL_US = 2000;
   localparam int unsigned T_RDR_BUSY_US = 190000;
   localparam int unsigned T_STACK_US = 8000;
   localparam int unsigned T_PCH_COL_US = 6250;
   localparam int unsigned T_EJECT_FAST_US = 88000;
   localparam int unsigned T_EJECT_SLOW_US = 120000;
   localparam int unsigned CARD_COLS = 80;
   localparam int unsigned EJECT_FAST_COLS = 72;
   localparam int unsigned PRN_XFERS = 137;
   localparam int unsigned SHORT_CYC = T_SHORT_US * CLK_MHZ;
   localparam int unsigned PRN_REQ_CYC = T_PRN_REQ_US * CLK_MHZ;
   localparam int unsigned RDR_COL_CYC = T_RDR_COL_US * CLK_MHZ;
   localparam int unsigned RDR_FEED_CYC = (T_RDR_BUSY_US - CARD_COLS * T_RDR_COL_US) * CLK_MHZ;
   localparam int unsigned STACK_CYC = T_STACK_US * CLK_MHZ;
   localparam int unsigned PCH_COL_CYC = T_PCH_COL_US * CLK_MHZ;
   localparam int unsigned EJECT_FAST_CYC = T_EJECT_FAST_US * CLK_MHZ;
   localparam int unsigned EJECT_SLOW_CYC = T_EJECT_SLOW_US * CLK_MHZ;

   // Register byte offsets
   localparam logic [11:0] REG_CMD = 12'h000;
   localparam logic [11:0] REG_DATA = 12'h004;
   localparam logic [11:0] REG_STAT = 12'h008;
   localparam logic [11:0] REG_COLS = 12'h00C;

   // Command word fields
   localparam int CMD_DEV_LSB = 0;
   localparam int CMD_STATUS_BIT = 2;
   localparam int CMD_XFER_BIT = 3;
   localparam int CMD_BINARY_BIT = 4;
   localparam logic [1:0] DEV_CTRL = 2'h0;
   localparam logic [1:0] DEV_PRN = 2'h1;
   localparam logic [1:0] DEV_RDR = 2'h2;
   localparam logic [1:0] DEV_PCH = 2'h3;
   localparam logic [15:0] CMD_RESET = 16'h0000;

   // Status word bits, numbered 1 (msb) to 16 (lsb) on the host side
   localparam int WORD_BITS = 16;
   localparam int ST_PRN_ONLINE = WORD_BITS - 9;
   localparam int ST_PRN_READY = WORD_BITS - 10;
   localparam int ST_RDR_ONLINE = WORD_BITS - 9;
   localparam int ST_RDR_ILLEGAL = WORD_BITS - 11;
   localparam int ST_RDR_OVERRUN = WORD_BITS - 12;
   localparam int ST_RDR_HOPPER = WORD_BITS - 14;
   localparam int ST_RDR_MOTION = WORD_BITS - 15;
   localparam int ST_RDR_RDCHK = WORD_BITS - 16;
   localparam int ST_PCH_ONLINE = WORD_BITS - 13;
   localparam int ST_PCH_OVERRUN = WORD_BITS - 14;
   localparam int ST_PCH_ATTN = WORD_BITS - 15;
   localparam int ST_PCH_CHECK = WORD_BITS - 16;

   // Block state register fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_READY = 1;
   localparam int STAT_STACKING = 2;
   localparam int STAT_EJECTING = 3;
   localparam int STAT_STATE_LSB = 4;

   typedef logic [23:0] ur_cnt_t;

   typedef enum logic [2:0] {
      UR_IDLE = 3'b000,
      UR_SHORT = 3'b001,
      UR_PRINT = 3'b010,
      UR_RWAIT = 3'b011,
      UR_READ = 3'b100,
      UR_PWAIT = 3'b101,
      UR_PUNCH = 3'b110
   } ur_state_e;

   typedef struct packed {
      logic prn_online;
      logic prn_ready;
      logic rdr_online;
      logic rdr_illegal;
      logic rdr_hopper_empty;
      logic rdr_motion_fail;
      logic rdr_light_fail;
      logic rdr_dark_fail;
      logic pch_online;
      logic pch_attn;
      logic pch_check_fail;
   } ur_pins_s;

   localparam int PIN_W = $bits(ur_pins_s);

endpackage

// *** dv/ur_far_model.sv ***
// Far-side model: the memory-transfer channel serving the three peripherals.
// Assumes pclk of the controller; the bench sets which acknowledge ends the range.
`timescale 1ns/1ns
module ur_far_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic mem_req,
   input wire logic [31:0] eor_at,
   output logic mem_ack,
   output logic mem_eor,
   output int acks
);
   logic [3:0] age_q;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         age_q <= 4'h0;
         mem_ack <= 1'b0;
         mem_eor <= 1'b0;
         acks <= 0;
      end
      else if (mem_req && !mem_ack && age_q == 4'h5)
      begin
         mem_ack <= 1'b1;
         mem_eor <= (acks + 1 == eor_at);
         acks <= acks + 1;
         age_q <= 4'h0;
      end
      else
      begin
         mem_ack <= 1'b0;
         // Outside an acknowledge the end flag toggles, so no stale value is trusted
         mem_eor <= !mem_eor;
         age_q <= (mem_req && !mem_ack) ? age_q + 4'h1 : 4'h0;
      end
   end
endmodule // ur_far_model

// *** dv/ur_ctrl_tb_top.sv ***
// Self-checking bench of the status and pacing controller.
// Assumes the far-side model on the memory channel and shortened card timing.
`timescale 1ns/1ns
module ur_ctrl_tb_top;
   import ur_pkg::*;
   typedef struct packed {ur_pins_s pins; logic [15:0] cmd; logic [15:0] word;} ur_row_s;
   localparam int COL = 40;
   localparam int PCOL = 50;
   localparam int FEED = 20;
   localparam int STK = 60;
   localparam int RD_MIN = FEED + CARD_COLS * COL;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rq;
   logic pready, pslverr, re, mem_req, mem_to_memory, mem_ack, mem_eor, busy, req_d, dir;
   ur_pins_s pins = '0;
   int eor_at = 0;
   int acks, n, gap, gap_min, nreq, ticks, bad_count, checks;
   ur_row_s rows [6] = '{'{11'h600, 16'h0005, 16'h00C0}, '{11'h200, 16'h0005, 16'h0040},
      '{11'h1F8, 16'h0006, 16'h0080}, '{11'h600, 16'h0006, 16'h0000},
      '{11'h004, 16'h0007, 16'h0008}, '{11'h003, 16'h0007, 16'h0003}};
   ur_ctrl #(.RDR_COL_CYC(COL), .RDR_FEED_CYC(FEED), .STACK_CYC(STK), .PCH_COL_CYC(PCOL),
      .EJECT_FAST_CYC(30), .EJECT_SLOW_CYC(45)) u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins), .mem_req(mem_req),
      .mem_to_memory(mem_to_memory), .mem_ack(mem_ack), .mem_eor(mem_eor), .busy(busy));
   ur_far_model u_far (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .eor_at(eor_at),
      .mem_ack(mem_ack), .mem_eor(mem_eor), .acks(acks));
   always #5 pclk = !pclk;
   task automatic conclude();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Holds the request until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge so a following call never drives psel twice in one step
      @(posedge pclk);
   endtask
   task automatic cmd(input logic [15:0] c, input int e);
      // A pending acknowledge would otherwise count toward the next range
      while (busy === 1'b1 || mem_req === 1'b1)
         @(posedge pclk);
      eor_at <= acks + e;
      nreq = 0;
      gap_min = 100000;
      apb(1'b1, REG_CMD, c);
      for (n = 0; busy === 1'b1; n++)
         @(posedge pclk);
      // Lets the monitor count a request raised at the final edge
      repeat (2) @(posedge pclk);
   endtask
   always @(posedge pclk)
   begin
      gap++;
      if (mem_req === 1'b1 && req_d !== 1'b1)
      begin
         if (nreq > 0 && gap < gap_min)
            gap_min = gap;
         nreq++;
         gap = 0;
         dir = mem_to_memory;
      end
      req_d = mem_req;
      ticks++;
      if (ticks > 40000)
      begin
         bad_count++;
         conclude();
      end
   end
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 6; i++)
      begin
         pins <= rows[i].pins;
         repeat (4) @(posedge pclk);
         cmd(rows[i].cmd, 99);
         chk("short busy", SHORT_CYC, n);
         apb(1'b0, REG_DATA, 16'h0);
         chk("status word", rows[i].word, rq);
      end
      apb(1'b1, REG_CMD, 16'h0005);
      apb(1'b1, REG_CMD, 16'h0005);
      chk("overlap refused", 1, re);
      apb(1'b0, 12'h010, 16'h0);
      chk("unmapped err", 1, re);
      chk("unmapped data", 0, rq);
      cmd(16'h0009, 3);
      chk("printer gap", 1, gap_min >= PRN_REQ_CYC);
      chk("printer reqs", 3, nreq);
      chk("printer dir", 0, dir);
      cmd(16'h000A, 99);
      chk("char reqs", 40, nreq);
      chk("char gap", 2 * COL, gap_min);
      cmd(16'h001A, 5);
      chk("read to memory", 1, dir);
      chk("eor reqs", 5, nreq);
      chk("bin gap", COL, gap_min);
      chk("read busy", 1, n >= RD_MIN && n <= RD_MIN + STK + 2);
      pins <= 11'h140;
      cmd(16'h001A, 99);
      chk("hopper reqs", 0, nreq);
      cmd(16'h0006, 99);
      apb(1'b0, REG_DATA, 16'h0);
      chk("hopper word", 16'h0084, rq[15:0]);
      cmd(16'h001B, 3);
      chk("punch gap", PCOL, gap_min);
      chk("punch busy", 1, nreq == 3 && n <= 3 * PCOL);
      chk("punch dir", 0, dir);
      cmd(16'h000B, 2);
      chk("punch char gap", 2 * PCOL, gap_min);
      chk("eject wait", 1, n >= 45 + 2 * PCOL);
      cmd(16'h001B, 99);
      chk("full card reqs", 80, nreq);
      chk("full card busy", 1, n > 79 * PCOL && n <= 80 * PCOL + 45);
      apb(1'b0, REG_COLS, 16'h0);
      chk("columns", CARD_COLS, rq);
      // Second reset lands in the middle of a punch order
      apb(1'b1, REG_CMD, 16'h001B);
      repeat (60) @(posedge pclk);
      chk("mid busy", 1, busy);
      presetn <= 1'b0;
      @(posedge pclk);
      chk("reset idle", 3'b000, {busy, mem_req, pready});
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("release idle", 3'b000, {busy, mem_req, pready});
      cmd(16'h0005, 99);
      chk("short after reset", SHORT_CYC, n);
      conclude();
   end
endmodule // ur_ctrl_tb_top
